// ### dac_core_cfg.svh
// Constants of the octal DAC command core: frame layout, command codes,
// power codes and pin idle levels.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef DAC_CORE_CFG_SVH
`define DAC_CORE_CFG_SVH

// Frame layout, most significant bit first on the wire.
`define FRAME_BITS        24
`define FRAME_CNT_W       5
`define CHANNELS          8
`define CODE_BITS         16
`define READBACK_PAD      8'h00

// Command codes carried in the top four bits of a frame.
`define CMD_NOP           4'h0
`define CMD_WRITE_INPUT   4'h1
`define CMD_UPDATE_DAC    4'h2
`define CMD_WRITE_UPDATE  4'h3
`define CMD_POWER         4'h4
`define CMD_CHAIN_SETUP   4'h8
`define CMD_READBACK      4'h9
`define CMD_WRITE_ALL_IN  4'ha
`define CMD_WRITE_ALL_BOTH 4'hb

// Power pair codes per channel.
`define PWR_NORMAL        2'h0
`define PWR_PULLDOWN      2'h1

// Reset values.
`define CHAIN_RESET       1'h0
`define CODE_RESET        16'h0000
`define POWER_RESET       2'h0
`define PIN_IDLE_HIGH     1'h1

`endif

// ### dac_core_pkg.sv
// Types shared by the octal DAC command core and its link logic.
// Assumes the constants header sits in the include path.
`include "dac_core_cfg.svh"

package dac_core_pkg;

   // One received frame, split into its fields.
   typedef struct packed {
      logic [3:0]  cmd;
      logic [3:0]  addr;
      logic [15:0] data;
   } frame_t;

   typedef logic [`CHANNELS-1:0][`CODE_BITS-1:0] code_bank_t;
   typedef logic [`CHANNELS-1:0][1:0]            power_bank_t;

   // Command core sequencing, one-hot.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_EXEC = 2'b10
   } core_state_t;

endpackage

// ### pin_sync3.sv
// Three-stage synchroniser for a pin from outside the reference clock.
// Assumes the pin may change at any time; the level is accepted once the
// second and third stages agree.
`timescale 1ns/100ps

module pin_sync3 #(
   parameter logic RST_VAL = 1'b1
) (
   // Clock, reset and enable.
   input  wire logic i_ref_clk,
   input  wire logic i_rst_b,
   input  wire logic i_clk_en,
   // Raw pin and accepted level.
   input  wire logic i_pin,
   output logic      o_level
);

   logic stage1_ff;
   logic stage2_ff;
   logic stage3_ff;

   // The first stage feeds only the second stage.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         stage1_ff <= RST_VAL;
         stage2_ff <= RST_VAL;
         stage3_ff <= RST_VAL;
         o_level   <= RST_VAL;
      end else if (i_clk_en) begin
         stage1_ff <= i_pin;
         stage2_ff <= stage1_ff;
         stage3_ff <= stage2_ff;
         if (stage2_ff == stage3_ff) begin
            o_level <= stage3_ff;
         end
      end
   end

endmodule

// ### serial_link_shifter.sv
// Serial-clock side of the command core: the 24-bit input shift register,
// the pass-through / readback serial output and its drive controls.
// Assumes the serial clock only runs while a frame is open or around it,
// and that core-side inputs are static while the frame strobe is low.
`timescale 1ns/100ps

`include "dac_core_cfg.svh"

module serial_link_shifter
   import dac_core_pkg::*;
(
   // Link pins.
   input  wire logic              i_sclk,
   input  wire logic              i_frame_n,
   input  wire logic              i_rst_b,
   input  wire logic              i_serial_in,
   // Static settings from the core.
   input  wire logic              i_chain_enable,
   input  wire logic              i_readback_arm,
   input  wire logic [15:0]       i_readback_code,
   // Received frame and serial output.
   output dac_core_pkg::frame_t   o_word,
   output logic                   o_serial_out,
   output logic                   o_serial_out_oe,
   output logic                   o_serial_out_keep
);

   logic [`FRAME_CNT_W-1:0] bit_cnt_ff;
   logic [`FRAME_BITS-1:0]  rb_word;
   logic [`FRAME_CNT_W-1:0] rb_index;
   logic                    frame_clr;
   logic                    nxt_serial_out;

   // The frame's own strobe ends per-frame state, since no edge follows.
   assign frame_clr = i_frame_n | ~i_rst_b;
   assign rb_word   = {`READBACK_PAD, i_readback_code};
   assign rb_index  = 5'd23 - bit_cnt_ff;
   // Readback bits first, then the ripple of older data.
   assign nxt_serial_out = (i_readback_arm && bit_cnt_ff < 5'd24) ?
                           rb_word[rb_index] : o_word[23];

   // Sample on falling edges only while the strobe is low.
   always_ff @(negedge i_sclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_word <= '0;
      end else if (!i_frame_n) begin
         o_word <= {o_word[22:0], i_serial_in};
      end
   end

   // Falling edges counted within a frame, saturating at one word.
   always_ff @(negedge i_sclk or posedge frame_clr) begin
      if (frame_clr) begin
         bit_cnt_ff <= '0;
      end else if (bit_cnt_ff != 5'd24) begin
         bit_cnt_ff <= bit_cnt_ff + 5'd1;
      end
   end

   // Output changes on rising edges; it holds its last bit between frames.
   always_ff @(posedge i_sclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_serial_out <= 1'b0;
      end else if (!i_frame_n) begin
         o_serial_out <= nxt_serial_out;
      end
   end

   // Strong drive during a frame only with chain enable or readback armed; weak keeper once the strobe rises.
   always_ff @(posedge i_sclk or posedge frame_clr) begin
      if (frame_clr) begin
         o_serial_out_oe   <= 1'b0;
         o_serial_out_keep <= 1'b1;
      end else begin
         o_serial_out_oe   <= i_chain_enable | i_readback_arm;
         o_serial_out_keep <= 1'b0;
      end
   end

endmodule

// ### dac_command_core.sv
// Octal DAC command core: takes 24-bit serial frames, executes them on the
// reference clock and holds the input, DAC and power registers.
// Assumes a separate serial clock, a frame strobe and a load pin that are
// all asynchronous to the reference clock, and a high strobe of at least
// five reference periods between frames.
// The clock enable freezes only the reference-clock state.
// Pair 10 of a power field is taken as three-state.
//
// Contract
// - Command 0010 copies the addressed input register into its DAC register.
// - Command 0011 updates DAC registers directly, whatever the load pin.
// - For 0011, data bits D7..D0 pick channels copied input to DAC.
// - Command 1000 sets chain enable from DB0; standalone after reset.
// - Strobe low: every clock shifts; beyond 24, old bits leave serially.
// - Serial output changes on rising clock edges, sampled on falling.
// - Strobe rising after any bit count still executes the held word.
// - Strobe rise latches the word; no shifting while strobe is high.
// - Command 1001 picks one channel by address; other bits ignored.
// - Serial output is driven during readback even in standalone mode.
// - Next frame shifts out four undefined bits, then the 16-bit value; the code sends eight zero pad bits first.
// - Strobe high: serial output only weakly holds its last bit.
// - Command 0100 loads 16 power bits, channel 7 at the top pair.
// - Power pair 00 normal, 01 pulldown resistor, 11 three-state.
// - Power-down leaves DAC registers intact and writes still land.
// - Two register stages per channel; load pin governs DAC transfers.
// - Frames are 24 bits MSB first: command, address, data.
// - Command 0001 writes the input register; load low also updates DAC.
// - Falling load pin copies every input register into its DAC register.
`timescale 1ns/100ps

`include "dac_core_cfg.svh"

module dac_command_core
   import dac_core_pkg::*;
(
   // Reference clock, reset and clock enable.
   input  wire logic                      i_ref_clk,
   input  wire logic                      i_rst_b,
   input  wire logic                      i_clk_en,
   // Serial link pins.
   input  wire logic                      i_sclk,
   input  wire logic                      i_frame_n,
   input  wire logic                      i_serial_in,
   output logic                           o_serial_out,
   output logic                           o_serial_out_oe,
   output logic                           o_serial_out_keep,
   // Load pin.
   input  wire logic                      i_load_outputs_n,
   // Channel state towards the analog section.
   output dac_core_pkg::code_bank_t       o_dac_code,
   output dac_core_pkg::power_bank_t      o_power_mode,
   // Output stage controls.
   output logic [`CHANNELS-1:0]           o_out_pulldown,
   output logic [`CHANNELS-1:0]           o_out_hiz,
   // Settings and status.
   output logic                           o_chain_enable,
   // Completion pulse.
   output logic                           o_frame_done
);

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------

   // Sequencer state.
   core_state_t  state_ff;
   core_state_t  nxt_state;

   // Word from the serial side.
   frame_t       link_word;

   // Channel banks.
   code_bank_t   input_code_ff;
   code_bank_t   nxt_input_code;
   code_bank_t   nxt_dac_code;
   power_bank_t  nxt_power_mode;

   // Output stage next values.
   logic [`CHANNELS-1:0] nxt_pulldown;
   logic [`CHANNELS-1:0] nxt_hiz;

   // Pin levels and edges.
   logic         frame_hi;
   logic         frame_hi_d_ff;
   logic         load_hi;
   logic         load_hi_d_ff;
   logic         frame_rise;
   logic         load_fall;

   // Execute cycle and channel address.
   logic         exec;
   logic         addr_ok;
   logic [2:0]   addr_ch;

   // Command strobes.
   logic         cmd_write_in;
   logic         cmd_update;
   logic         cmd_write_upd;
   logic         cmd_power;
   logic         cmd_chain;
   logic         cmd_readback;
   logic         cmd_all_in;
   logic         cmd_all_both;

   // Readback state.
   logic         readback_arm_ff;
   logic         nxt_readback_arm;
   logic [15:0]  readback_code_ff;
   logic [15:0]  nxt_readback_code;

   // Chain setting.
   logic         nxt_chain_enable;

   // -----------------------------------------------------------------
   // Serial-clock domain
   // -----------------------------------------------------------------

   // The shift word crosses as a static word: it cannot move while the
   // strobe is high, and the core reads it only after seeing that high
   // level through its synchroniser. The settings going the other way
   // only change while the strobe is high, so they are static in a frame.
   // The price is a minimum high gap on the strobe; a shorter gap can
   // let a new frame shift while the core still reads the old word.
   serial_link_shifter u_link (
      .i_sclk            (i_sclk),
      .i_frame_n         (i_frame_n),
      .i_rst_b           (i_rst_b),
      .i_serial_in       (i_serial_in),
      .i_chain_enable    (o_chain_enable),
      .i_readback_arm    (readback_arm_ff),
      .i_readback_code   (readback_code_ff),
      .o_word            (link_word),
      .o_serial_out      (o_serial_out),
      .o_serial_out_oe   (o_serial_out_oe),
      .o_serial_out_keep (o_serial_out_keep)
   );

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------

   // Both pins idle high, so reset assumes the idle level.
   // Three stages keep metastability out of the decode, at the
   // cost of about four reference periods per edge.
   pin_sync3 #(
      .RST_VAL (`PIN_IDLE_HIGH)
   ) u_frame_sync (
      .i_ref_clk (i_ref_clk),
      .i_rst_b   (i_rst_b),
      .i_clk_en  (i_clk_en),
      .i_pin     (i_frame_n),
      .o_level   (frame_hi)
   );

   // The load pin is treated like the strobe.
   pin_sync3 #(
      .RST_VAL (`PIN_IDLE_HIGH)
   ) u_load_sync (
      .i_ref_clk (i_ref_clk),
      .i_rst_b   (i_rst_b),
      .i_clk_en  (i_clk_en),
      .i_pin     (i_load_outputs_n),
      .o_level   (load_hi)
   );

   // Edge detection on the accepted levels.
   // A strobe rise starts execution; a load fall copies.
   assign frame_rise = frame_hi & ~frame_hi_d_ff;
   assign load_fall  = ~load_hi & load_hi_d_ff;

   // Delayed levels reset to the idle level too, so the release
   // of reset is never taken for an edge.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         frame_hi_d_ff <= `PIN_IDLE_HIGH;
         load_hi_d_ff  <= `PIN_IDLE_HIGH;
      end else if (i_clk_en) begin
         frame_hi_d_ff <= frame_hi;
         load_hi_d_ff  <= load_hi;
      end
   end

   // -----------------------------------------------------------------
   // Sequencing
   // -----------------------------------------------------------------

   // Any strobe rise executes, whatever the bit count was; the word is
   // read one cycle later so the edge detector and the word agree.
   // Execution lasts one cycle, so a word is applied once.
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (frame_rise) begin
               nxt_state = ST_EXEC;
            end
         end
         ST_EXEC: begin
            nxt_state = ST_IDLE;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // State register; a low enable holds the sequence.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_ff <= ST_IDLE;
      end else if (i_clk_en) begin
         state_ff <= nxt_state;
      end
   end

   // -----------------------------------------------------------------
   // Command decode
   // -----------------------------------------------------------------

   // The word is steady here, since the strobe is still high.
   // Only addresses 0 to 7 name a channel; higher ones select nothing.
   assign exec          = (state_ff == ST_EXEC);
   assign addr_ok       = (link_word.addr[3] == 1'b0);
   assign addr_ch       = link_word.addr[2:0];

   // One strobe per code; reserved codes raise none.
   assign cmd_write_in  = exec && link_word.cmd == `CMD_WRITE_INPUT;
   assign cmd_update    = exec && link_word.cmd == `CMD_UPDATE_DAC;
   assign cmd_write_upd = exec && link_word.cmd == `CMD_WRITE_UPDATE;
   assign cmd_power     = exec && link_word.cmd == `CMD_POWER;
   assign cmd_chain     = exec && link_word.cmd == `CMD_CHAIN_SETUP;
   assign cmd_readback  = exec && link_word.cmd == `CMD_READBACK;

   // Commands that act on every channel.
   assign cmd_all_in    = exec && link_word.cmd == `CMD_WRITE_ALL_IN;
   assign cmd_all_both  = exec && link_word.cmd == `CMD_WRITE_ALL_BOTH;

   // -----------------------------------------------------------------
   // Per-channel registers
   // -----------------------------------------------------------------

   // Every channel has an input stage and a DAC stage. A falling load
   // pin in the same cycle as a command copies the old input value;
   // a command that writes the DAC stage directly wins over that copy.
   for (genvar ch = 0; ch < `CHANNELS; ch++) begin : g_chan
      logic sel;
      logic wr_input;
      logic wr_dac_data;
      logic copy_input;

      // Channel named by the address field.
      assign sel = addr_ok && (addr_ch == 3'(ch));

      // Write terms first, then the copy terms.
      assign wr_input = (cmd_write_in && sel) || cmd_all_in ||
                        cmd_all_both;
      assign wr_dac_data = (cmd_write_in && sel && !load_hi) ||
                           cmd_all_both;
      assign copy_input = (cmd_update && sel) ||
                          (cmd_write_upd && link_word.data[ch]) ||
                          load_fall;

      // The input stage moves only on a write.
      assign nxt_input_code[ch] = wr_input ? link_word.data :
                                  input_code_ff[ch];

      // Power mode is not consulted, so writes land while powered down.
      assign nxt_dac_code[ch] = wr_dac_data ? link_word.data :
                                copy_input  ? input_code_ff[ch] :
                                o_dac_code[ch];

      // Channel 7 takes the top pair of the data word.
      assign nxt_power_mode[ch] = cmd_power ? link_word.data[2*ch +: 2] :
                                  o_power_mode[ch];
      assign nxt_pulldown[ch] = (nxt_power_mode[ch] == `PWR_PULLDOWN);

      // Pair 10 has no defined mode; it is treated as three-state.
      assign nxt_hiz[ch] = nxt_power_mode[ch][1];
   end

   // Input and DAC stages of all channels.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         input_code_ff <= {`CHANNELS{`CODE_RESET}};
         o_dac_code    <= {`CHANNELS{`CODE_RESET}};
      end else if (i_clk_en) begin
         input_code_ff <= nxt_input_code;
         o_dac_code    <= nxt_dac_code;
      end
   end

   // Power state and its decoded drive controls move together.
   // Registering the decode keeps the controls glitch-free.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_power_mode   <= {`CHANNELS{`POWER_RESET}};
         o_out_pulldown <= '0;
         o_out_hiz      <= '0;
      end else if (i_clk_en) begin
         o_power_mode   <= nxt_power_mode;
         o_out_pulldown <= nxt_pulldown;
         o_out_hiz      <= nxt_hiz;
      end
   end

   // -----------------------------------------------------------------
   // Chain enable and readback
   // -----------------------------------------------------------------

   // Reserved codes and no-operation fall through every select above,
   // so only the readback arm, which lasts one frame, is touched.
   assign nxt_chain_enable = cmd_chain ? link_word.data[0] :
                             o_chain_enable;

   // The arm is cleared by whichever frame follows the readback frame.
   // An address of 8 or above arms nothing.
   assign nxt_readback_arm = exec ? cmd_readback && addr_ok :
                             readback_arm_ff;

   // The snapshot is taken at execution; the other data bits are unused.
   // A write between the two frames leaves the snapshot alone.
   assign nxt_readback_code = (cmd_readback && addr_ok) ?
                              o_dac_code[addr_ch] :
                              readback_code_ff;

   // Settings, readback state and the done pulse.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_chain_enable   <= `CHAIN_RESET;
         readback_arm_ff  <= 1'b0;
         readback_code_ff <= `CODE_RESET;
         o_frame_done     <= 1'b0;
      end else if (i_clk_en) begin
         o_chain_enable   <= nxt_chain_enable;
         readback_arm_ff  <= nxt_readback_arm;
         readback_code_ff <= nxt_readback_code;
         o_frame_done     <= exec;
      end
   end

endmodule

// ### dac_command_core_checker.sv
// Concurrent checks for the octal DAC command core, on its top ports.
// Assumes the clock enable is held high by the bench throughout.
`timescale 1ns/100ps

`include "dac_core_cfg.svh"

module dac_command_core_checker
   import dac_core_pkg::*;
(
   // Clock, reset and pins.
   input  wire logic                     i_ref_clk,
   input  wire logic                     i_rst_b,
   input  wire logic                     i_frame_n,
   input  wire logic                     i_load_outputs_n,
   // Observed outputs.
   input  wire logic                     o_serial_out_oe,
   input  wire logic                     o_serial_out_keep,
   input  wire dac_core_pkg::code_bank_t  o_dac_code,
   input  wire dac_core_pkg::power_bank_t o_power_mode,
   input  wire logic [`CHANNELS-1:0]     o_out_pulldown,
   input  wire logic [`CHANNELS-1:0]     o_out_hiz,
   input  wire logic                     o_chain_enable,
   input  wire logic                     o_frame_done
);
   logic [`CHANNELS-1:0] pd_exp;
   logic [`CHANNELS-1:0] hz_exp;

   // Output stage expected from the power pairs; 10 counts as three-state.
   always_comb begin
      for (int c = 0; c < `CHANNELS; c++) begin
         pd_exp[c] = (o_power_mode[c] == 2'h1);
         hz_exp[c] = o_power_mode[c][1];
      end
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);

   chk_keep_idle: assert property (i_frame_n && $past(i_frame_n)
      |-> o_serial_out_keep) else $error("keeper off between frames");
   chk_oe_idle: assert property (i_frame_n && $past(i_frame_n)
      |-> !o_serial_out_oe) else $error("strong drive between frames");
   chk_done_follows: assert property ($rose(i_frame_n)
      |-> ##[2:10] o_frame_done) else $error("frame not executed");
   chk_done_single: assert property (o_frame_done
      |=> !o_frame_done) else $error("done longer than one cycle");
   chk_chain_cause: assert property (!$stable(o_chain_enable)
      |-> o_frame_done) else $error("chain setting moved without frame");
   chk_power_cause: assert property (!$stable(o_power_mode)
      |-> o_frame_done) else $error("power pairs moved without frame");
   chk_dac_cause: assert property (!$stable(o_dac_code)
      && i_load_outputs_n && $past(i_load_outputs_n, 8) |-> o_frame_done)
      else $error("dac code moved without frame or load");
   chk_pulldown_map: assert property (o_out_pulldown == pd_exp)
      else $error("pulldown does not follow power pairs");
   chk_hiz_map: assert property (o_out_hiz == hz_exp)
      else $error("three-state does not follow power pairs");
endmodule

// ### spi_host_model.sv
// Serial host model: frame strobe, gated 30 ns serial clock, data out,
// and capture of the device's serial output on falling clock edges.
// Assumes the device samples on falling and drives on rising edges.
`timescale 1ns/100ps

module spi_host_model (
   // Link lines towards the device.
   output logic      o_sclk,
   output logic      o_frame_n,
   output logic      o_serial_in,
   // Device serial output and its strong drive enable.
   input  wire logic i_serial_out,
   input  wire logic i_serial_out_oe
);
   // The clock idles low and runs only inside a frame.
   initial begin
      o_sclk      = 1'b0;
      o_frame_n   = 1'b1;
      o_serial_in = 1'b0;
   end

   // Sends the low n bits of w MSB first; rx keeps the last 24 bits seen.
   task automatic xfer(input logic [47:0] w, input int n,
                       output logic [23:0] rx, output logic oe_seen);
      rx = 24'h0;
      oe_seen = 1'b0;
      #7;
      o_frame_n = 1'b0;
      #15;
      for (int k = n - 1; k >= 0; k--) begin
         o_sclk = 1'b1;
         o_serial_in = w[k];
         #15;
         o_sclk = 1'b0;
         rx = {rx[22:0], i_serial_out};
         oe_seen = oe_seen | i_serial_out_oe;
         #15;
      end
      // Strobe rises after the last clock of the burst.
      o_frame_n = 1'b1;
      // Released data line shows no stale level.
      o_serial_in = ~o_serial_in;
   endtask
endmodule

// ### tb_dac_command_core.sv
// Self-checking bench for the octal DAC command core: frames go through
// the host model and results are read at the channel outputs.
// Assumes the checker and the host model are compiled before this file.
`timescale 1ns/100ps

module tb_dac_command_core;
   import dac_core_pkg::*;

   logic        i_ref_clk, i_rst_b, i_load_outputs_n;
   logic        ser_clk, frm_n, ser_in, oe;
   logic        o_serial_out, o_serial_out_oe, o_serial_out_keep;
   code_bank_t  o_dac_code, exp_dac;
   power_bank_t o_power_mode, exp_pw;
   logic [7:0]  o_out_pulldown, o_out_hiz;
   logic        o_chain_enable, o_frame_done, exp_ch;
   logic [23:0] rx;
   logic [3:0]  rsv [8] = '{4'h0, 4'h5, 4'h6, 4'h7, 4'hc, 4'hd, 4'he, 4'hf};
   int          n_mismatch, n_tests;

   dac_command_core dac_command_core_inst (
      .i_ref_clk, .i_rst_b, .i_clk_en(1'b1), .i_sclk(ser_clk),
      .i_frame_n(frm_n), .i_serial_in(ser_in), .o_serial_out,
      .o_serial_out_oe, .o_serial_out_keep, .i_load_outputs_n,
      .o_dac_code, .o_power_mode, .o_out_pulldown, .o_out_hiz,
      .o_chain_enable, .o_frame_done);

   spi_host_model spi_host_model_inst (
      .o_sclk(ser_clk), .o_frame_n(frm_n), .o_serial_in(ser_in),
      .i_serial_out(o_serial_out), .i_serial_out_oe(o_serial_out_oe));

   initial i_ref_clk = 1'b0;
   always #20 i_ref_clk = ~i_ref_clk;

   task automatic check(input logic [127:0] seen, input logic [127:0] want);
      n_tests++;
      if (seen !== want) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
      end
   endtask

   task automatic check_all();
      check(o_dac_code, exp_dac);
      check(128'(o_power_mode), 128'(exp_pw));
      check(128'(o_chain_enable), 128'(exp_ch));
   endtask

   // One frame, then a bounded wait for execution and a safe strobe gap.
   task automatic frame(input logic [47:0] w, input int n);
      int k;
      spi_host_model_inst.xfer(w, n, rx, oe);
      for (k = 0; k < 20 && o_frame_done !== 1'b1; k++)
         @(negedge i_ref_clk);
      check(128'(k < 20), 128'(1));
      repeat (3) @(negedge i_ref_clk);
   endtask

   task automatic wr(input logic [3:0] c, input logic [3:0] a,
                     input logic [15:0] d);
      frame({24'h0, c, a, d}, 24);
   endtask

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // A hang is cut short well beyond the expected run of some 30 us.
   initial begin
      #200000;
      n_mismatch++;
      conclude();
   end

   initial begin
      n_mismatch = 0;
      n_tests = 0;
      i_rst_b = 1'b0;
      i_load_outputs_n = 1'b1;
      exp_dac = '0;
      exp_pw = '0;
      exp_ch = 1'b0;
      repeat (8) @(posedge i_ref_clk);
      i_rst_b <= 1'b1;
      @(negedge i_ref_clk);
      check_all();
      // Deferred write, then single-channel and masked transfers.
      wr(4'h1, 4'h2, 16'habcd);
      check_all();
      wr(4'h2, 4'h2, 16'h0000);
      exp_dac[2] = 16'habcd;
      check_all();
      wr(4'h1, 4'h3, 16'h1234);
      wr(4'h1, 4'h5, 16'h5555);
      wr(4'h3, 4'h0, 16'hff28);
      exp_dac[3] = 16'h1234;
      exp_dac[5] = 16'h5555;
      check_all();
      // Load pin edge copies every channel; held low it is transparent.
      wr(4'h1, 4'h0, 16'h0f0f);
      wr(4'h1, 4'h6, 16'h6666);
      @(posedge i_ref_clk);
      i_load_outputs_n <= 1'b0;
      repeat (8) @(negedge i_ref_clk);
      exp_dac[0] = 16'h0f0f;
      exp_dac[6] = 16'h6666;
      check_all();
      wr(4'h1, 4'h1, 16'h1111);
      exp_dac[1] = 16'h1111;
      check_all();
      @(posedge i_ref_clk);
      i_load_outputs_n <= 1'b1;
      repeat (8) @(negedge i_ref_clk);
      // Power pairs, ignored bits set, then a write while powered down.
      wr(4'h4, 4'h7, 16'hc00d);
      exp_pw = 16'hc00d;
      check_all();
      check(128'(o_out_pulldown), 128'(8'h01));
      check(128'(o_out_hiz), 128'(8'h82));
      wr(4'h1, 4'h7, 16'h7777);
      wr(4'h2, 4'h7, 16'h0000);
      exp_dac[7] = 16'h7777;
      check_all();
      foreach (rsv[i])
         wr(rsv[i], 4'h0, 16'hffff);
      check_all();
      // Readback of channel 3 through a following zero frame.
      wr(4'h9, 4'h3, 16'hffff);
      frame(48'h0, 24);
      check(128'(rx[15:0]), 128'(exp_dac[3]));
      check(128'(oe), 128'(1));
      // Broadcast writes: input stages only, then both stages.
      wr(4'ha, 4'h0, 16'h2222);
      wr(4'h2, 4'h4, 16'h0000);
      exp_dac[4] = 16'h2222;
      check_all();
      wr(4'hb, 4'h0, 16'h3333);
      exp_dac = {8{16'h3333}};
      check_all();
      // Short frame completes a chain setup left in the shift register.
      frame(48'h000800, 24);
      check(128'(oe), 128'(0));
      frame(48'h001, 12);
      exp_ch = 1'b1;
      check_all();
      frame({24'ha5c30f, 24'h800000}, 48);
      exp_ch = 1'b0;
      check(128'(rx), 128'(24'ha5c30f));
      check(128'(oe), 128'(1));
      check_all();
      conclude();
   end
endmodule

bind dac_command_core dac_command_core_checker dac_command_core_checker_inst (
   .i_ref_clk, .i_rst_b, .i_frame_n, .i_load_outputs_n, .o_serial_out_oe,
   .o_serial_out_keep, .o_dac_code, .o_power_mode, .o_out_pulldown,
   .o_out_hiz, .o_chain_enable, .o_frame_done);
